/* core/bbt_defines.vh */
// Constants of the bit-boundary block transfer engine
`ifndef BBT_DEFINES_VH
`define BBT_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BBT_OFF_CTRL    4'h0
`define BBT_OFF_ACC1    4'h4
`define BBT_OFF_ACC2    4'h8
`define BBT_OFF_STAT    4'hC

// ----------------------------------------
// Register fields and reset values
// ----------------------------------------
`define BBT_CTRL_ISSUE  0
`define BBT_CTRL_STORE  1
`define BBT_STAT_BUSY   0
`define BBT_STAT_DONE   1
`define BBT_STAT_TRAP   2
`define BBT_STAT_SUSP   3
`define BBT_RST_STORE   1'b0
`define BBT_RST_ACC     16'h0000

// ----------------------------------------
// Descriptor word indices
// ----------------------------------------
`define BBT_W_FUNC      4'd0
`define BBT_W_DBA       4'd2
`define BBT_W_DRW       4'd3
`define BBT_W_DLX       4'd4
`define BBT_W_DTY       4'd5
`define BBT_W_DW        4'd6
`define BBT_W_DH        4'd7
`define BBT_W_SBA       4'd8
`define BBT_W_SRW       4'd9
`define BBT_W_SLX       4'd10
`define BBT_W_STY       4'd11
`define BBT_W_PAT0      4'd12
`define BBT_W_LAST      4'd15

// ----------------------------------------
// Function word fields and encodings
// ----------------------------------------
`define BBT_FN_SRC_ALT  10
`define BBT_FN_DST_ALT  11
`define BBT_FN_STYPE    12
`define BBT_FN_OP       14
`define BBT_ST_BLOCK    2'h0
`define BBT_ST_COMPL    2'h1
`define BBT_ST_MASKED   2'h2
`define BBT_ST_PAT      2'h3
`define BBT_OP_REPLACE  2'h0
`define BBT_OP_PAINT    2'h1
`define BBT_OP_INVERT   2'h2
`define BBT_OP_ERASE    2'h3

`endif

/* core/bbt_edge_mask.v */
// Edge mask of one destination word
`timescale 1ns/1ps
module bbt_edge_mask (
	input  wire [11:0] word_idx,
	input  wire [15:0] left_x,
	input  wire [15:0] width,
	output reg  [15:0] mask
);
	integer    c;
	reg [15:0] x;
	reg [15:0] off;

	// Unsigned distance test covers both edges while width stays non-negative
	always @* begin
		mask = 16'h0000;
		x    = 16'h0000;
		off  = 16'h0000;
		for (c = 0; c < 16; c = c + 1) begin
			x            = {word_idx, c[3:0]};
			off          = x - left_x;
			mask[15 - c] = (off < width);
		end
	end
endmodule // bbt_edge_mask

/* core/bbt_combine.v */
// Source alignment, source term, combining operation and edge merge
`timescale 1ns/1ps
`include "bbt_defines.vh"
module bbt_combine (
	input  wire [15:0] src_hi,
	input  wire [15:0] src_lo,
	input  wire [3:0]  skew,
	input  wire [15:0] dst,
	input  wire [15:0] pattern,
	input  wire [15:0] mask,
	input  wire [1:0]  stype,
	input  wire [1:0]  op,
	output wire [15:0] result
);
	wire [31:0] pair    = {src_hi, src_lo};
	wire [31:0] shifted = pair << skew;
	wire [15:0] aligned = shifted[31:16];
	reg  [15:0] term;
	reg  [15:0] res;

	always @* begin
		case (stype)
			`BBT_ST_BLOCK:  term = aligned;
			`BBT_ST_COMPL:  term = ~aligned;
			`BBT_ST_MASKED: term = aligned & pattern;
			default:        term = pattern;
		endcase
	end

	always @* begin
		case (op)
			`BBT_OP_REPLACE: res = term;
			`BBT_OP_PAINT:   res = term | dst;
			`BBT_OP_INVERT:  res = term ^ dst;
			default:         res = ~term & dst;
		endcase
	end

	// Bits outside the rectangle keep the old destination value
	assign result = (res & mask) | (dst & ~mask);
endmodule // bbt_combine

/* core/bbt_engine.v */
// Bit-boundary block transfer engine with Avalon-MM registers and word memory master
// ----------------------------------------
// Overview of operation
// - On completion only accumulator_two is guaranteed; others may hold anything.
// - Without the writable control store, issuing traps as unimplemented, no transfer.
// - Sixteen-word descriptor: function, unused, destination six, source four, four patterns.
// - Negative destination height or width: no writes, finish at once.
// - Interrupt only at scan line start; progress to accumulator_one, program counter backed.
// - Function bit 10 puts source, bit 11 destination, in alternate bank.
// - Bits 14-15 pick replace, OR, XOR or and-not with destination.
// - Bits 12-13 pick source, complement, source AND pattern, or pattern.
// - One pattern word per line, cycling four words in processing order.
// - Top to bottom when destination top is above source top, else upward.
// - Source rectangle takes the destination width and height.
// - Overlapping rectangles are ordered so the result matches an unmodified source.
// - Rectangles sit at any bit position; partial edge words are merged.
// - Aim for few cycles per word and modest start-up cost.
// - Most significant bit of a word is the leftmost pixel.
// ----------------------------------------
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "bbt_defines.vh"
module bbt_engine (
	input  wire        mclk,
	input  wire        rst,
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	output reg         mem_req,
	output reg         mem_we,
	output reg         mem_alt_bank,
	output reg  [15:0] mem_addr,
	output reg  [15:0] mem_wdata,
	input  wire        mem_ack,
	input  wire [15:0] mem_rdata,
	input  wire        irq_pending,
	output reg         pc_backup,
	output reg         op_trap
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [6:0] S_IDLE = 7'b000_0001;
	localparam [6:0] S_DESC = 7'b000_0010;
	localparam [6:0] S_LINE = 7'b000_0100;
	localparam [6:0] S_SRC0 = 7'b000_1000;
	localparam [6:0] S_SRC1 = 7'b001_0000;
	localparam [6:0] S_DST  = 7'b010_0000;
	localparam [6:0] S_WR   = 7'b100_0000;

	reg [6:0]  state_q;
	reg [15:0] desc_q [0:15];
	reg [3:0]  idx_q;
	reg [15:0] acc1_q;
	reg [15:0] acc2_q;
	reg        store_q;
	reg        busy_q;
	reg        done_q;
	reg        trap_q;
	reg        susp_q;
	reg        moved_q;
	reg [15:0] line_q;
	reg [11:0] wi_q;
	reg [15:0] dline_q;
	reg [15:0] sline_q;
	reg [15:0] srca_q;
	reg [15:0] srcb_q;
	reg [15:0] dstw_q;
	reg [31:0] rd_d;

	// ----------------------------------------
	// Descriptor fields
	// ----------------------------------------
	wire [15:0] fn  = desc_q[`BBT_W_FUNC];
	wire [15:0] dba = desc_q[`BBT_W_DBA];
	wire [15:0] drw = desc_q[`BBT_W_DRW];
	wire [15:0] dest_left_x = desc_q[`BBT_W_DLX];
	wire [15:0] dest_top_y = desc_q[`BBT_W_DTY];
	wire [15:0] dw  = desc_q[`BBT_W_DW];
	wire [15:0] dh  = desc_q[`BBT_W_DH];
	wire [15:0] sba = desc_q[`BBT_W_SBA];
	wire [15:0] srw = desc_q[`BBT_W_SRW];
	wire [15:0] src_left_x = desc_q[`BBT_W_SLX];
	wire [15:0] src_top_y = desc_q[`BBT_W_STY];
	wire [1:0]  stype = fn[`BBT_FN_STYPE+1:`BBT_FN_STYPE];
	wire [1:0]  op    = fn[`BBT_FN_OP+1:`BBT_FN_OP];
	wire [15:0] pat   = desc_q[`BBT_W_PAT0 + {2'b00, line_q[1:0]}];

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	wire        topdown = $signed(dest_top_y) < $signed(src_top_y);
	wire        rtl     = $signed(dest_left_x) > $signed(src_left_x);
	wire [15:0] dlast_x = dest_left_x + dw - 16'h0001;
	wire [11:0] wfirst  = dest_left_x[15:4];
	wire [11:0] wlast   = dlast_x[15:4];
	wire [11:0] wend    = rtl ? wfirst : wlast;
	wire [15:0] yoff    = topdown ? line_q : (dh - 16'h0001 - line_q);
	wire [15:0] dy      = dest_top_y + yoff;
	wire [15:0] sy      = src_top_y + yoff;
	wire [31:0] dprod   = dy * drw;
	wire [31:0] sprod   = sy * srw;
	wire [15:0] dwaddr  = dline_q + {4'h0, wi_q};
	wire [15:0] xs0     = {wi_q, 4'h0} + src_left_x - dest_left_x;
	wire [15:0] swaddr  = sline_q + {{4{xs0[15]}}, xs0[15:4]};
	wire        no_op   = dw[15] | dh[15] | (dw == 16'h0000) | (dh == 16'h0000);
	wire        pat_only = (stype == `BBT_ST_PAT);
	wire [15:0] mask;
	wire [15:0] result;

	bbt_edge_mask u_mask (
		.word_idx (wi_q),
		.left_x   (dest_left_x),
		.width    (dw),
		.mask     (mask)
	);

	bbt_combine u_comb (
		.src_hi  (srca_q),
		.src_lo  (srcb_q),
		.skew    (xs0[3:0]),
		.dst     (dstw_q),
		.pattern (pat),
		.mask    (mask),
		.stype   (stype),
		.op      (op),
		.result  (result)
	);

	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	always @* begin
		rd_d = 32'h0000_0000;
		if (avs_address == `BBT_OFF_CTRL) begin
			rd_d[`BBT_CTRL_STORE] = store_q;
		end else if (avs_address == `BBT_OFF_ACC1) begin
			rd_d[15:0] = acc1_q;
		end else if (avs_address == `BBT_OFF_ACC2) begin
			rd_d[15:0] = acc2_q;
		end else if (avs_address == `BBT_OFF_STAT) begin
			rd_d[`BBT_STAT_BUSY] = busy_q;
			rd_d[`BBT_STAT_DONE] = done_q;
			rd_d[`BBT_STAT_TRAP] = trap_q;
			rd_d[`BBT_STAT_SUSP] = susp_q;
		end
	end

	// ----------------------------------------
	// Bus slave: one wait state per access
	// ----------------------------------------
	wire wr_go = avs_write & ~avs_waitrequest;
	wire issue = wr_go & (avs_address == `BBT_OFF_CTRL) & avs_writedata[`BBT_CTRL_ISSUE];

	always @(posedge mclk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			if ((avs_read | avs_write) & avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
			end else begin
				avs_waitrequest <= 1'b1;
			end
			if (avs_read & avs_waitrequest) begin
				avs_readdata <= rd_d;
			end
		end
	end

	// ----------------------------------------
	// Transfer sequencer
	// ----------------------------------------
	always @(posedge mclk) begin
		if (rst) begin
			state_q      <= S_IDLE;
			idx_q        <= 4'h0;
			acc1_q       <= `BBT_RST_ACC;
			acc2_q       <= `BBT_RST_ACC;
			store_q      <= `BBT_RST_STORE;
			busy_q       <= 1'b0;
			done_q       <= 1'b0;
			trap_q       <= 1'b0;
			susp_q       <= 1'b0;
			moved_q      <= 1'b0;
			line_q       <= 16'h0000;
			wi_q         <= 12'h000;
			dline_q      <= 16'h0000;
			sline_q      <= 16'h0000;
			srca_q       <= 16'h0000;
			srcb_q       <= 16'h0000;
			dstw_q       <= 16'h0000;
			mem_req      <= 1'b0;
			mem_we       <= 1'b0;
			mem_alt_bank <= 1'b0;
			mem_addr     <= 16'h0000;
			mem_wdata    <= 16'h0000;
			pc_backup    <= 1'b0;
			op_trap      <= 1'b0;
		end else begin
			pc_backup <= 1'b0;
			op_trap   <= 1'b0;
			// Accumulators are frozen while a transfer owns them
			if (wr_go & ~busy_q) begin
				if (avs_address == `BBT_OFF_CTRL) begin
					store_q <= avs_writedata[`BBT_CTRL_STORE];
				end else if (avs_address == `BBT_OFF_ACC1) begin
					acc1_q <= avs_writedata[15:0];
				end else if (avs_address == `BBT_OFF_ACC2) begin
					acc2_q <= avs_writedata[15:0];
				end
			end
			case (state_q)
				S_IDLE: begin
					if (issue) begin
						done_q <= 1'b0;
						susp_q <= 1'b0;
						if (!store_q) begin
							trap_q  <= 1'b1;
							op_trap <= 1'b1;
						end else begin
							trap_q  <= 1'b0;
							busy_q  <= 1'b1;
							idx_q   <= 4'h0;
							state_q <= S_DESC;
						end
					end
				end
				S_DESC: begin
					if (!mem_req) begin
						mem_req      <= 1'b1;
						mem_we       <= 1'b0;
						mem_alt_bank <= 1'b0;
						mem_addr     <= acc2_q + {12'h000, idx_q};
					end else if (mem_ack) begin
						mem_req       <= 1'b0;
						desc_q[idx_q] <= mem_rdata;
						idx_q         <= idx_q + 4'h1;
						if (idx_q == `BBT_W_LAST) begin
							state_q <= S_LINE;
							line_q  <= acc1_q;
							moved_q <= 1'b0;
						end
					end
				end
				S_LINE: begin
					if (no_op || line_q >= dh) begin
						// Only the table pointer is promised back
						acc1_q  <= 16'h0000;
						busy_q  <= 1'b0;
						done_q  <= 1'b1;
						state_q <= S_IDLE;
					end else if (irq_pending && moved_q) begin
						acc1_q    <= line_q;
						pc_backup <= 1'b1;
						busy_q    <= 1'b0;
						susp_q    <= 1'b1;
						state_q   <= S_IDLE;
					end else begin
						dline_q <= dba + dprod[15:0];
						sline_q <= sba + sprod[15:0];
						wi_q    <= rtl ? wlast : wfirst;
						state_q <= pat_only ? S_DST : S_SRC0;
					end
				end
				S_SRC0: begin
					if (!mem_req) begin
						mem_req      <= 1'b1;
						mem_we       <= 1'b0;
						mem_alt_bank <= fn[`BBT_FN_SRC_ALT];
						mem_addr     <= swaddr;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						srca_q  <= mem_rdata;
						state_q <= S_SRC1;
					end
				end
				S_SRC1: begin
					// Second word feeds the bits that spill past a word edge
					if (!mem_req) begin
						mem_req      <= 1'b1;
						mem_we       <= 1'b0;
						mem_alt_bank <= fn[`BBT_FN_SRC_ALT];
						mem_addr     <= swaddr + 16'h0001;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						srcb_q  <= mem_rdata;
						state_q <= S_DST;
					end
				end
				S_DST: begin
					if (!mem_req) begin
						mem_req      <= 1'b1;
						mem_we       <= 1'b0;
						mem_alt_bank <= fn[`BBT_FN_DST_ALT];
						mem_addr     <= dwaddr;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						dstw_q  <= mem_rdata;
						state_q <= S_WR;
					end
				end
				S_WR: begin
					if (!mem_req) begin
						mem_req      <= 1'b1;
						mem_we       <= 1'b1;
						mem_alt_bank <= fn[`BBT_FN_DST_ALT];
						mem_addr     <= dwaddr;
						mem_wdata    <= result;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						mem_we  <= 1'b0;
						if (wi_q == wend) begin
							line_q  <= line_q + 16'h0001;
							moved_q <= 1'b1;
							state_q <= S_LINE;
						end else begin
							// Walk toward unread source words on overlap
							wi_q    <= rtl ? wi_q - 12'h001 : wi_q + 12'h001;
							state_q <= pat_only ? S_DST : S_SRC0;
						end
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule // bbt_engine

/* testbench/bbt_engine_properties.sv */
// Concurrent checks on the block transfer engine's bus and memory ports
`timescale 1ns/1ps
module bbt_engine_props (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic        mem_alt_bank,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic        mem_ack,
	input wire logic        irq_pending,
	input wire logic        pc_backup,
	input wire logic        op_trap
);
	// ----------------------------------------
	// Handshake sequences and properties
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_bus_take;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_mem_wait;
		mem_req && !mem_ack;
	endsequence
	bus_answer_a: assert property (s_bus_take |=> !avs_waitrequest)
		else $error("bus access not answered after one wait state");
	bus_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer longer than one cycle");
	bus_cause_a: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
		else $error("bus answer without a request");
	mem_hold_a: assert property (s_mem_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we)
		&& $stable(mem_alt_bank) && $stable(mem_wdata))
		else $error("memory request changed before ack");
	mem_gap_a: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("memory request not dropped after ack");
	trap_quiet_a: assert property (op_trap |-> !mem_req ##1 !mem_req [*3])
		else $error("memory traffic around a trap");
	trap_pulse_a: assert property (op_trap |=> !op_trap)
		else $error("trap pulse too long");
	pc_pulse_a: assert property (pc_backup |=> !pc_backup && !mem_req)
		else $error("backup pulse too long or traffic after suspend");
	pc_cause_a: assert property (pc_backup |-> $past(irq_pending))
		else $error("suspend without interrupt request");
endmodule // bbt_engine_props

bind bbt_engine bbt_engine_props u_props (
	.mclk(mclk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.mem_req(mem_req), .mem_we(mem_we), .mem_alt_bank(mem_alt_bank), .mem_addr(mem_addr),
	.mem_wdata(mem_wdata), .mem_ack(mem_ack), .irq_pending(irq_pending), .pc_backup(pc_backup), .op_trap(op_trap)
);

/* testbench/bbt_mem_model.sv */
// Two-bank word memory answering the engine's master port
`timescale 1ns/1ps
module bbt_mem_model (
	input  wire logic        mclk,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic        mem_alt_bank,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output logic             mem_ack,
	output logic      [15:0] mem_rdata,
	input  wire logic [2:0]  slow
);
	logic [15:0] bank0 [0:255];
	logic [15:0] bank1 [0:255];
	logic [2:0]  wait_q = 3'h0;
	int          wr_cnt = 0;
	int          acc_cnt = 0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 16'h0000;
		for (int i = 0; i < 256; i++) begin
			bank0[i] = 16'h0000;
			bank1[i] = 16'h0000;
		end
	end
	// Data is only valid with ack; scramble it otherwise
	always @(posedge mclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			wait_q <= wait_q + 3'h1;
			if (wait_q >= slow) begin
				wait_q <= 3'h0;
				mem_ack <= 1'b1;
				acc_cnt <= acc_cnt + 1;
				if (mem_we) begin
					wr_cnt <= wr_cnt + 1;
					if (mem_alt_bank) bank1[mem_addr[7:0]] <= mem_wdata;
					else bank0[mem_addr[7:0]] <= mem_wdata;
				end else
					mem_rdata <= mem_alt_bank ? bank1[mem_addr[7:0]] : bank0[mem_addr[7:0]];
			end
		end
	end
endmodule // bbt_mem_model

/* testbench/tb.sv */
// Self-checking bench for the block transfer engine
`timescale 1ns/1ps
module tb;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic        irq_pending = 1'b0;
	logic [2:0]  slow = 3'h0;
	logic        pc_seen = 1'b0;
	logic        trap_seen = 1'b0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, mem_req, mem_we, mem_alt_bank, mem_ack, pc_backup, op_trap;
	logic [15:0] mem_addr, mem_wdata, mem_rdata;
	// Unphased on purpose: word checks do not care about seams
	logic [15:0] pat [0:3] = '{16'hF0F0, 16'hCCCC, 16'h3C3C, 16'h0FF0};
	int          err_total = 0;
	int          num_checks = 0;
	int          cyc = 0;

	always #5 mclk = ~mclk;
	bbt_engine u_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we), .mem_alt_bank(mem_alt_bank),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.irq_pending(irq_pending), .pc_backup(pc_backup), .op_trap(op_trap));
	bbt_mem_model u_mem (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we), .mem_alt_bank(mem_alt_bank),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow));
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (pc_backup === 1'b1) pc_seen <= 1'b1;
		if (op_trap === 1'b1) trap_seen <= 1'b1;
		if (cyc == 80000) begin
			err_total++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Bus and comparison helpers
	// ----------------------------------------
	task chk(input string what, input [15:0] exp, input [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task av_wr(input [3:0] a, input [15:0] d);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= 1'b1;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	task av_rd(input [3:0] a, output [15:0] d);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		d = avs_readdata[15:0];
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task desc(input [15:0] fn, dest_left_x, dw, dh, src_top_y);
		logic [15:0] w [0:15];
		w = '{fn, 16'h0000, 16'h00A0, 16'h0001, dest_left_x, 16'h0004, dw, dh, 16'h0080, 16'h0001, 16'h0000, src_top_y,
			pat[0], pat[1], pat[2], pat[3]};
		for (int i = 0; i < 16; i++) u_mem.bank0[8'h40 + i] = w[i];
	endtask
	task run(input [15:0] ctrl, acc1, output [15:0] st);
		logic [15:0] a2;
		av_wr(4'h4, acc1);
		av_wr(4'h8, 16'h0040);
		// Store flag first: issue looks at the flag held before its own write
		av_wr(4'h0, ctrl & 16'h0002);
		av_wr(4'h0, ctrl);
		st = 16'h0001;
		while (st[0] !== 1'b0) av_rd(4'hC, st);
		av_rd(4'h8, a2);
		chk("table pointer", 16'h0040, a2);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_trap;
		logic [15:0] st;
		int          n;
		n = u_mem.acc_cnt;
		run(16'h0001, 16'h0000, st);
		chk("trap status", 16'h0004, st);
		chk("trap traffic", 16'h0000, 16'(u_mem.acc_cnt - n));
		chk("trap pulse", 16'h0001, {15'h0000, trap_seen});
	endtask
	task t_ops;
		logic [4:0]  c;
		logic [15:0] s, p, t, f, st, v;
		logic        alt;
		for (c = 0; c < 16; c++) begin
			alt = (c[3:2] == 2'h2);
			slow <= c[2:0];
			for (int y = 0; y < 2; y++) begin
				v = y ? 16'h1234 : 16'hABCD;
				u_mem.bank0[8'hA4 + y] = 16'h5A5A;
				u_mem.bank1[8'hA4 + y] = 16'h5A5A;
				u_mem.bank0[8'h80 + 8 * c[0] + y] = alt ? ~v : v;
				u_mem.bank1[8'h80 + 8 * c[0] + y] = v;
			end
			desc({c[1:0], c[3:2], alt, alt, 10'h000}, 16'h0004, 16'h0008, 16'h0002, {12'h000, c[0], 3'h0});
			run(16'h0003, 16'h0000, st);
			chk("done status", 16'h0002, st);
			for (int y = 0; y < 2; y++) begin
				s = (y ? 16'h1234 : 16'hABCD) >> 4;
				p = pat[c[0] ? y : 1 - y];
				case (c[3:2])
					2'h0: t = s;
					2'h1: t = ~s;
					2'h2: t = s & p;
					default: t = p;
				endcase
				case (c[1:0])
					2'h0: f = t;
					2'h1: f = t | 16'h5A5A;
					2'h2: f = t ^ 16'h5A5A;
					default: f = ~t & 16'h5A5A;
				endcase
				v = alt ? u_mem.bank1[8'hA4 + y] : u_mem.bank0[8'hA4 + y];
				chk("dest word", (f & 16'h0FF0) | 16'h500A, v);
				if (alt) chk("main bank word", 16'h5A5A, u_mem.bank0[8'hA4 + y]);
			end
		end
		slow <= 3'h1;
	endtask
	task t_nop;
		logic [15:0] st;
		int          n;
		for (int i = 0; i < 2; i++) begin
			desc(16'h0000, 16'h0000, i ? 16'hFFFF : 16'h0010, i ? 16'h0002 : 16'hFFFF, 16'h0000);
			n = u_mem.wr_cnt;
			run(16'h0003, 16'h0000, st);
			chk("nop status", 16'h0002, st);
			chk("nop writes", 16'h0000, 16'(u_mem.wr_cnt - n));
		end
	endtask
	task t_irq;
		logic [15:0] st, a1;
		for (int y = 0; y < 4; y++) begin
			u_mem.bank0[8'h80 + y] = {4{4'(y + 1)}};
			u_mem.bank0[8'hA4 + y] = 16'h0000;
		end
		desc(16'h0000, 16'h0000, 16'h0010, 16'h0004, 16'h0000);
		irq_pending <= 1'b1;
		pc_seen <= 1'b0;
		run(16'h0003, 16'h0000, st);
		chk("suspend status", 16'h0008, st);
		chk("backup pulse", 16'h0001, {15'h0000, pc_seen});
		av_rd(4'h4, a1);
		chk("progress", 16'h0001, a1);
		irq_pending <= 1'b0;
		run(16'h0003, a1, st);
		chk("resume status", 16'h0002, st);
		for (int y = 0; y < 4; y++) chk("resumed word", {4{4'(y + 1)}}, u_mem.bank0[8'hA4 + y]);
	endtask
	// Source and destination in one bit map, moved down then up by two lines
	task t_ovl;
		logic [15:0] st;
		int          s;
		for (int k = 0; k < 2; k++) begin
			s = k ? 6 : 2;
			for (int r = 0; r < 12; r++) u_mem.bank0[8'hA0 + r] = 16'(r * 16'h0101);
			desc(16'h0000, 16'h0000, 16'h0010, 16'h0004, 16'(s));
			u_mem.bank0[8'h48] = 16'h00A0;
			run(16'h0003, 16'h0000, st);
			chk("overlap status", 16'h0002, st);
			for (int y = 0; y < 4; y++) chk("overlap word", 16'((y + s) * 16'h0101), u_mem.bank0[8'hA4 + y]);
		end
	endtask

	task stop_test;
		if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_trap();
		t_ops();
		t_nop();
		t_irq();
		t_ovl();
		stop_test();
	end
endmodule // tb
